// ---- rtl/supply_guard_pkg.sv ----
package supply_guard_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W  = 10;
  localparam int unsigned REG_W  = 8;

  // Register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_OSC_CTRL   = 10'h1e0;
  localparam logic [IDX_W-1:0] IDX_VDET_CTRL  = 10'h1e3;
  localparam logic [IDX_W-1:0] IDX_VCMP_STAT  = 10'h1e4;
  localparam logic [IDX_W-1:0] IDX_SLEEP_TRIM = 10'h1eb;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT   = 10'h1f0;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 10'h1f1;

  // Reset values
  localparam logic [REG_W-1:0] RST_REG = 8'h00;

  // Oscillator control fields
  localparam int unsigned OSC_SPEED_LSB = 0;
  localparam int unsigned OSC_SPEED_W   = 3;
  localparam int unsigned OSC_SLEEP_LSB = 3;
  localparam int unsigned OSC_SLEEP_W   = 2;
  localparam int unsigned OSC_NOBUZZ    = 5;
  localparam logic [REG_W-1:0] OSC_WMASK = 8'h3f;

  // Voltage detect control fields
  localparam int unsigned VD_SEL_LSB  = 0;
  localparam int unsigned VD_SEL_W    = 3;
  localparam int unsigned VD_LEV_LSB  = 4;
  localparam int unsigned VD_LEV_W    = 2;
  localparam logic [REG_W-1:0] VD_WMASK = 8'h37;

  // Comparator status fields
  localparam int unsigned CMP_PWR_BIT = 0;
  localparam int unsigned CMP_LOW_BIT = 1;

  // Sleep duty trim fields
  localparam int unsigned TRIM_LSB = 6;
  localparam int unsigned TRIM_W   = 2;
  localparam logic [REG_W-1:0] TRIM_WMASK = 8'hc0;

  // Trip codes
  localparam logic [VD_LEV_W-1:0] LEV_HIGH    = 2'h2;
  localparam logic [VD_SEL_W-1:0] SEL_4V73    = 3'h6;
  localparam logic [VD_SEL_W-1:0] SEL_4V82    = 3'h7;

  // Highest speed code that stays at or below 12 MHz
  localparam logic [OSC_SPEED_W-1:0] SPEED_12M_MAX = 3'h3;

  // Interrupt event bits
  localparam int unsigned EV_W         = 4;
  localparam int unsigned EV_LOW_SET   = 0;
  localparam int unsigned EV_LOW_CLR   = 1;
  localparam int unsigned EV_PWR_RST   = 2;
  localparam int unsigned EV_SPEED_BAD = 3;

  // Bus answer states
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ACK
  } bus_state_t;

endpackage

// ---- rtl/level_sync.sv ----
module level_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  // Two flops per bit, first one read only by second
  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        meta_q[g] <= 1'b0;
        sync_o[g] <= 1'b0;
      end else begin
        meta_q[g] <= async_i[g];
        sync_o[g] <= meta_q[g];
      end
    end
  end

endmodule

// ---- rtl/event_flags.sv ----
module event_flags #(
  parameter int unsigned WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Events and software access
  input  wire logic [WIDTH-1:0] event_i,
  input  wire logic             clear_i,
  input  wire logic [WIDTH-1:0] clear_bits_i,
  input  wire logic             mask_we_i,
  input  wire logic [WIDTH-1:0] mask_i,
  // State
  output logic      [WIDTH-1:0] status_o,
  output logic      [WIDTH-1:0] mask_o,
  output logic                  irq_o
);

  logic [WIDTH-1:0] clr;

  // Write one to clear, only on the strobe
  assign clr = clear_i ? clear_bits_i : '0;

  // Sticky bits, a new event beats a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= '0;
    end else begin
      status_o <= (status_o & ~clr) | event_i;
    end
  end

  // Enable mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_o <= '0;
    end else if (mask_we_i) begin
      mask_o <= mask_i;
    end
  end

  // Level interrupt from next state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((status_o & ~clr) | event_i) & (mask_we_i ? mask_i : mask_o));
    end
  end

endmodule

// ---- rtl/supply_monitor_speed_guard.sv ----
// Operation
// - Level code 10b selects high reset trip
// - Detector uses three-bit trip select field
// - Comparator status bit 1 shows low voltage
// - Reset trip defaults low after reset
// - Maskable interrupt on supply dip below trip
module supply_monitor_speed_guard (
  // Clock and reset
  input  wire logic                                   clk_i,
  input  wire logic                                   rst_i,
  // Wishbone slave
  input  wire logic                                   cyc_i,
  input  wire logic                                   stb_i,
  input  wire logic                                   we_i,
  input  wire logic [supply_guard_pkg::ADDR_W-1:0]    adr_i,
  input  wire logic [3:0]                             sel_i,
  input  wire logic [supply_guard_pkg::DATA_W-1:0]    dat_i,
  output logic      [supply_guard_pkg::DATA_W-1:0]    dat_o,
  output logic                                        ack_o,
  // CPU flags
  input  wire logic                                   ext_space_select_i,
  // Analog comparator levels
  input  wire logic                                   low_voltage_raw_i,
  input  wire logic                                   power_reset_raw_i,
  // Analog and clock controls
  output logic      [supply_guard_pkg::VD_LEV_W-1:0]  reset_trip_level_o,
  output logic                                        high_trip_o,
  output logic      [supply_guard_pkg::VD_SEL_W-1:0]  detect_trip_select_o,
  output logic                                        detect_above_reset_o,
  output logic      [supply_guard_pkg::OSC_SPEED_W-1:0] cpu_speed_o,
  output logic      [supply_guard_pkg::OSC_SLEEP_W-1:0] sleep_timer_o,
  output logic                                        no_buzz_o,
  output logic      [supply_guard_pkg::TRIM_W-1:0]    sleep_duty_o,
  // Interrupt
  output logic                                        irq_o
);

  import supply_guard_pkg::*;

  // Bus state
  bus_state_t bus_state_q;
  logic       bus_req;
  logic       bus_wr;
  logic       bus_rd;
  logic [IDX_W-1:0] bus_idx;
  logic [REG_W-1:0] wr_byte;
  logic       lane0;

  // Registers
  logic [REG_W-1:0] osc_ctrl_q;
  logic [REG_W-1:0] osc_ctrl_d;
  logic [REG_W-1:0] vdet_ctrl_q;
  logic [REG_W-1:0] vdet_ctrl_d;
  logic [REG_W-1:0] vcmp_stat_q;
  logic [REG_W-1:0] sleep_trim_q;
  logic [REG_W-1:0] sleep_trim_d;
  logic [REG_W-1:0] rd_byte;

  // Synchronised comparator levels
  logic low_voltage_flag;
  logic power_reset_flag;
  logic low_voltage_prev_q;
  logic power_reset_prev_q;

  // Events
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] irq_status;
  logic [EV_W-1:0] irq_mask;
  logic            stat_clear;
  logic            mask_we;
  logic            speed_bad;
  logic            speed_bad_q;

  // Register write strobes
  logic            osc_we;
  logic            vdet_we;
  logic            trim_we;

  // Register select helper, used for reads and writes
  function automatic logic hit(input logic [IDX_W-1:0] idx,
                               input logic [IDX_W-1:0] reg_idx);
    hit = (idx == reg_idx);
  endfunction

  // Speed above the 12 MHz band
  function automatic logic fast_speed(input logic [OSC_SPEED_W-1:0] code);
    fast_speed = (code > SPEED_12M_MAX);
  endfunction

  // Speed field of an oscillator control byte
  function automatic logic [OSC_SPEED_W-1:0] speed_code(input logic [REG_W-1:0] ctrl);
    speed_code = ctrl[OSC_SPEED_LSB +: OSC_SPEED_W];
  endfunction

  // Reset trip level field of a detect control byte
  function automatic logic [VD_LEV_W-1:0] trip_level(input logic [REG_W-1:0] ctrl);
    trip_level = ctrl[VD_LEV_LSB +: VD_LEV_W];
  endfunction

  // Detector select field of a detect control byte
  function automatic logic [VD_SEL_W-1:0] trip_select(input logic [REG_W-1:0] ctrl);
    trip_select = ctrl[VD_SEL_LSB +: VD_SEL_W];
  endfunction

  // Detector codes that sit above the reset level
  function automatic logic above_reset(input logic [VD_SEL_W-1:0] sel);
    above_reset = (sel == SEL_4V73) || (sel == SEL_4V82);
  endfunction

  // Event bits widened to a register byte
  function automatic logic [REG_W-1:0] ev_byte(input logic [EV_W-1:0] bits);
    ev_byte = {{(REG_W-EV_W){1'b0}}, bits};
  endfunction

  // Request decode; extended space only reachable with the flag set
  assign bus_req = cyc_i && stb_i && (bus_state_q == BUS_IDLE);
  assign bus_idx = adr_i[ADDR_W-1:2];
  assign lane0   = sel_i[0];
  assign wr_byte = dat_i[REG_W-1:0];
  assign bus_wr  = bus_req && we_i && lane0 && ext_space_select_i;
  assign bus_rd  = bus_req && !we_i && ext_space_select_i;

  // Write strobes per register
  assign osc_we  = bus_wr && hit(bus_idx, IDX_OSC_CTRL);
  assign vdet_we = bus_wr && hit(bus_idx, IDX_VDET_CTRL);
  assign trim_we = bus_wr && hit(bus_idx, IDX_SLEEP_TRIM);

  // One answer per request, ack drops for a cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state_q <= BUS_IDLE;
      ack_o       <= 1'b0;
    end else begin
      case (bus_state_q)
        BUS_IDLE: begin
          if (cyc_i && stb_i) begin
            bus_state_q <= BUS_ACK;
            ack_o       <= 1'b1;
          end
        end
        BUS_ACK: begin
          bus_state_q <= BUS_IDLE;
          ack_o       <= 1'b0;
        end
        default: begin
          bus_state_q <= BUS_IDLE;
          ack_o       <= 1'b0;
        end
      endcase
    end
  end

  // Oscillator control next value
  always_comb begin
    osc_ctrl_d = osc_ctrl_q;
    if (osc_we) begin
      osc_ctrl_d = wr_byte & OSC_WMASK;
    end
  end

  // Oscillator control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_ctrl_q <= RST_REG;
    end else begin
      osc_ctrl_q <= osc_ctrl_d;
    end
  end

  // Voltage detect control next value, reserved bits stay zero
  always_comb begin
    vdet_ctrl_d = vdet_ctrl_q;
    if (vdet_we) begin
      vdet_ctrl_d = wr_byte & VD_WMASK;
    end
  end

  // Voltage detect control register, low trip after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vdet_ctrl_q <= RST_REG;
    end else begin
      vdet_ctrl_q <= vdet_ctrl_d;
    end
  end

  // Sleep duty trim next value
  always_comb begin
    sleep_trim_d = sleep_trim_q;
    if (trim_we) begin
      sleep_trim_d = wr_byte & TRIM_WMASK;
    end
  end

  // Sleep duty trim register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_trim_q <= RST_REG;
    end else begin
      sleep_trim_q <= sleep_trim_d;
    end
  end

  // Comparator levels cross into the clock domain
  level_sync #(
    .WIDTH (2)
  ) u_cmp_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({low_voltage_raw_i, power_reset_raw_i}),
    .sync_o  ({low_voltage_flag, power_reset_flag})
  );

  // Comparator status, read only mirror of synced levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vcmp_stat_q <= RST_REG;
    end else begin
      vcmp_stat_q              <= RST_REG;
      vcmp_stat_q[CMP_LOW_BIT] <= low_voltage_flag;
      vcmp_stat_q[CMP_PWR_BIT] <= power_reset_flag;
    end
  end

  // Previous levels for edge events
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_voltage_prev_q <= 1'b0;
      power_reset_prev_q <= 1'b0;
    end else begin
      low_voltage_prev_q <= low_voltage_flag;
      power_reset_prev_q <= power_reset_flag;
    end
  end

  // Fast speed selected while trip is not high
  assign speed_bad = fast_speed(speed_code(osc_ctrl_q)) &&
                     (trip_level(vdet_ctrl_q) != LEV_HIGH);

  // Speed guard edge tracking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_bad_q <= 1'b0;
    end else begin
      speed_bad_q <= speed_bad;
    end
  end

  // Event pulses
  always_comb begin
    events               = '0;
    events[EV_LOW_SET]   = low_voltage_flag && !low_voltage_prev_q;
    events[EV_LOW_CLR]   = !low_voltage_flag && low_voltage_prev_q;
    events[EV_PWR_RST]   = power_reset_flag && !power_reset_prev_q;
    events[EV_SPEED_BAD] = speed_bad && !speed_bad_q;
  end

  // Status clear and mask write strobes
  assign stat_clear = bus_wr && hit(bus_idx, IDX_IRQ_STAT);
  assign mask_we    = bus_wr && hit(bus_idx, IDX_IRQ_MASK);

  // Sticky status, mask and interrupt line
  event_flags #(
    .WIDTH (EV_W)
  ) u_events (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .event_i      (events),
    .clear_i      (stat_clear),
    .clear_bits_i (wr_byte[EV_W-1:0]),
    .mask_we_i    (mask_we),
    .mask_i       (wr_byte[EV_W-1:0]),
    .status_o     (irq_status),
    .mask_o       (irq_mask),
    .irq_o        (irq_o)
  );

  // Read multiplexer, unmapped reads return zero
  always_comb begin
    rd_byte = RST_REG;
    if (hit(bus_idx, IDX_OSC_CTRL)) begin
      rd_byte = osc_ctrl_q;
    end else if (hit(bus_idx, IDX_VDET_CTRL)) begin
      rd_byte = vdet_ctrl_q;
    end else if (hit(bus_idx, IDX_VCMP_STAT)) begin
      rd_byte = vcmp_stat_q;
    end else if (hit(bus_idx, IDX_SLEEP_TRIM)) begin
      rd_byte = sleep_trim_q;
    end else if (hit(bus_idx, IDX_IRQ_STAT)) begin
      rd_byte = ev_byte(irq_status);
    end else if (hit(bus_idx, IDX_IRQ_MASK)) begin
      rd_byte = ev_byte(irq_mask);
    end
  end

  // Read data register, cleared by other requests, held while idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (bus_rd) begin
      dat_o <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
    end else if (bus_req) begin
      dat_o <= '0;
    end
  end

  // Reset trip controls for the analog supervisor
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_trip_level_o <= '0;
      high_trip_o        <= 1'b0;
    end else begin
      reset_trip_level_o <= trip_level(vdet_ctrl_d);
      high_trip_o        <= (trip_level(vdet_ctrl_d) == LEV_HIGH);
    end
  end

  // Detector trip select for the analog comparator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      detect_trip_select_o <= '0;
      detect_above_reset_o <= 1'b0;
    end else begin
      detect_trip_select_o <= trip_select(vdet_ctrl_d);
      detect_above_reset_o <= above_reset(trip_select(vdet_ctrl_d));
    end
  end

  // Clock controls; speed changes follow firmware ordering
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_speed_o   <= '0;
      sleep_timer_o <= '0;
      no_buzz_o     <= 1'b0;
    end else begin
      cpu_speed_o   <= speed_code(osc_ctrl_d);
      sleep_timer_o <= osc_ctrl_d[OSC_SLEEP_LSB +: OSC_SLEEP_W];
      no_buzz_o     <= osc_ctrl_d[OSC_NOBUZZ];
    end
  end

  // Sleep duty trim output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_duty_o <= '0;
    end else begin
      sleep_duty_o <= sleep_trim_d[TRIM_LSB +: TRIM_W];
    end
  end

endmodule

// ---- dv/supply_guard_properties.sv ----
module supply_guard_properties
  import supply_guard_pkg::*;
(
  // Clock and reset
  input wire logic                                   clk_i,
  input wire logic                                   rst_i,
  // Bus
  input wire logic                                   cyc_i,
  input wire logic                                   stb_i,
  input wire logic                                   we_i,
  input wire logic [supply_guard_pkg::ADDR_W-1:0]    adr_i,
  input wire logic [3:0]                             sel_i,
  input wire logic [supply_guard_pkg::DATA_W-1:0]    dat_i,
  input wire logic [supply_guard_pkg::DATA_W-1:0]    dat_o,
  input wire logic                                   ack_o,
  // Flags and analog side
  input wire logic                                   ext_space_select_i,
  input wire logic                                   low_voltage_raw_i,
  input wire logic [supply_guard_pkg::VD_LEV_W-1:0]  reset_trip_level_o,
  input wire logic                                   high_trip_o,
  input wire logic [supply_guard_pkg::VD_SEL_W-1:0]  detect_trip_select_o,
  input wire logic                                   detect_above_reset_o,
  input wire logic [supply_guard_pkg::OSC_SPEED_W-1:0] cpu_speed_o,
  input wire logic [supply_guard_pkg::TRIM_W-1:0]    sleep_duty_o,
  input wire logic                                   irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Decoded request
  wire logic [IDX_W-1:0] idx = adr_i[11:2];
  wire logic             wr_ok = cyc_i && stb_i && !ack_o && we_i && ext_space_select_i && sel_i[0];

  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_cmp_rd;
    s_req ##0 (!we_i && ext_space_select_i && idx == IDX_VCMP_STAT);
  endsequence

  property p_ack_next;
    s_req |=> ack_o;
  endproperty
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  property p_high_trip;
    high_trip_o == (reset_trip_level_o == LEV_HIGH);
  endproperty
  property p_above;
    detect_above_reset_o == (detect_trip_select_o >= SEL_4V73);
  endproperty
  property p_vdet_wr;
    wr_ok && idx == IDX_VDET_CTRL |=> reset_trip_level_o == $past(dat_i[5:4])
      && detect_trip_select_o == $past(dat_i[2:0]);
  endproperty
  property p_no_ext;
    s_req ##0 !ext_space_select_i |=> $stable(cpu_speed_o) && $stable(reset_trip_level_o)
      && ($past(we_i) || dat_o == '0);
  endproperty
  property p_low_read;
    $stable(low_voltage_raw_i) [*5] ##0 s_cmp_rd |=> dat_o[CMP_LOW_BIT] == $past(low_voltage_raw_i);
  endproperty
  property p_mask_off;
    wr_ok && idx == IDX_IRQ_MASK && dat_i[EV_W-1:0] == '0 |=> ##1 !irq_o;
  endproperty
  property p_reset_zero;
    $fell(rst_i) |-> cpu_speed_o == '0 && reset_trip_level_o == '0 && sleep_duty_o == '0 && !irq_o;
  endproperty

  a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_high_trip: assert property (p_high_trip) else $error("high trip output wrong");
  a_above: assert property (p_above) else $error("detector above reset flag wrong");
  a_vdet_wr: assert property (p_vdet_wr) else $error("detect control write lost");
  a_no_ext: assert property (p_no_ext) else $error("access without ext flag acted");
  a_low_read: assert property (p_low_read) else $error("low voltage bit wrong");
  a_mask_off: assert property (p_mask_off) else $error("masked interrupt still high");
  a_reset_zero: assert property (p_reset_zero) else $error("outputs not zero after reset");
endmodule

bind supply_monitor_speed_guard supply_guard_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .ext_space_select_i(ext_space_select_i), .low_voltage_raw_i(low_voltage_raw_i),
  .reset_trip_level_o(reset_trip_level_o), .high_trip_o(high_trip_o),
  .detect_trip_select_o(detect_trip_select_o), .detect_above_reset_o(detect_above_reset_o),
  .cpu_speed_o(cpu_speed_o), .sleep_duty_o(sleep_duty_o), .irq_o(irq_o)
);

// ---- dv/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import supply_guard_pkg::*;

  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, ext_space_select_i;
  logic low_voltage_raw_i, power_reset_raw_i, high_trip_o, detect_above_reset_o;
  logic no_buzz_o, irq_o;
  logic [ADDR_W-1:0] adr_i;
  logic [3:0] sel_i;
  logic [DATA_W-1:0] dat_i, dat_o;
  logic [VD_LEV_W-1:0] reset_trip_level_o;
  logic [VD_SEL_W-1:0] detect_trip_select_o;
  logic [OSC_SPEED_W-1:0] cpu_speed_o;
  logic [OSC_SLEEP_W-1:0] sleep_timer_o;
  logic [TRIM_W-1:0] sleep_duty_o;
  int fail_count = 0;
  int checked = 0;

  supply_monitor_speed_guard u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ext_space_select_i(ext_space_select_i), .low_voltage_raw_i(low_voltage_raw_i),
    .power_reset_raw_i(power_reset_raw_i), .reset_trip_level_o(reset_trip_level_o),
    .high_trip_o(high_trip_o), .detect_trip_select_o(detect_trip_select_o),
    .detect_above_reset_o(detect_above_reset_o), .cpu_speed_o(cpu_speed_o),
    .sleep_timer_o(sleep_timer_o), .no_buzz_o(no_buzz_o), .sleep_duty_o(sleep_duty_o),
    .irq_o(irq_o)
  );

  // Clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [IDX_W-1:0] ix, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {ix, 2'b00};
    dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1);
    check("ack_wait", n, 32'd2);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic wr(input logic [IDX_W-1:0] ix, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, ix, d, q);
  endtask

  task automatic rd_chk(input string nm, input logic [IDX_W-1:0] ix, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, ix, 8'h00, q);
    check(nm, q, {24'h000000, e});
  endtask

  task automatic t_reset_values();
    logic [IDX_W-1:0] ix[6] = '{IDX_OSC_CTRL, IDX_VDET_CTRL, IDX_VCMP_STAT, IDX_SLEEP_TRIM,
                                IDX_IRQ_STAT, IDX_IRQ_MASK};
    foreach (ix[i]) rd_chk("reset_reg", ix[i], 8'h00);
    check("reset_outs", {cpu_speed_o, reset_trip_level_o, sleep_duty_o, irq_o}, 32'h0);
  endtask

  task automatic t_masks();
    wr(IDX_OSC_CTRL, 8'hff);
    wr(IDX_VDET_CTRL, 8'hff);
    wr(IDX_SLEEP_TRIM, 8'hff);
    wr(IDX_VCMP_STAT, 8'hff);
    wr(10'h100, 8'hff);
    rd_chk("osc", IDX_OSC_CTRL, 8'h3f);
    rd_chk("vdet", IDX_VDET_CTRL, 8'h37);
    rd_chk("trim", IDX_SLEEP_TRIM, 8'hc0);
    rd_chk("cmp_ro", IDX_VCMP_STAT, 8'h00);
    rd_chk("unmapped", 10'h100, 8'h00);
    check("osc_outs", {cpu_speed_o, sleep_timer_o, no_buzz_o, sleep_duty_o}, 32'hff);
  endtask

  task automatic t_trip_codes();
    for (int i = 0; i < 8; i++) begin
      wr(IDX_VDET_CTRL, {2'b00, i[1:0], 1'b0, i[2:0]});
      check("level", reset_trip_level_o, i[1:0]);
      check("high", high_trip_o, i[1:0] == 2'b10);
      check("sel", detect_trip_select_o, i[2:0]);
      check("above", detect_above_reset_o, i >= 6);
    end
  endtask

  task automatic t_ext_flag();
    wr(IDX_OSC_CTRL, 8'h05);
    ext_space_select_i <= 1'b0;
    wr(IDX_OSC_CTRL, 8'h2a);
    rd_chk("noext_rd", IDX_OSC_CTRL, 8'h00);
    ext_space_select_i <= 1'b1;
    rd_chk("noext_wr", IDX_OSC_CTRL, 8'h05);
    sel_i <= 4'he;
    wr(IDX_OSC_CTRL, 8'h2a);
    sel_i <= 4'hf;
    rd_chk("lane_wr", IDX_OSC_CTRL, 8'h05);
  endtask

  task automatic t_low_voltage();
    wr(IDX_VDET_CTRL, 8'h26);
    wr(IDX_IRQ_MASK, 8'h00);
    wr(IDX_IRQ_STAT, 8'h0f);
    low_voltage_raw_i <= 1'b1;
    idle(8);
    rd_chk("cmp_low", IDX_VCMP_STAT, 8'h02);
    check("irq_masked", irq_o, 32'h0);
    rd_chk("ev_rise", IDX_IRQ_STAT, 8'h01);
    wr(IDX_IRQ_MASK, 8'h01);
    idle(2);
    check("irq_on", irq_o, 32'h1);
    wr(IDX_IRQ_STAT, 8'h01);
    idle(2);
    check("irq_clr", irq_o, 32'h0);
    low_voltage_raw_i <= 1'b0;
    power_reset_raw_i <= 1'b1;
    idle(8);
    rd_chk("cmp_ok", IDX_VCMP_STAT, 8'h01);
    rd_chk("ev_fall", IDX_IRQ_STAT, 8'h06);
    power_reset_raw_i <= 1'b0;
  endtask

  task automatic t_speed_guard();
    wr(IDX_OSC_CTRL, 8'h00);
    wr(IDX_VDET_CTRL, 8'h06);
    wr(IDX_IRQ_STAT, 8'h0f);
    wr(IDX_IRQ_MASK, 8'h08);
    wr(IDX_OSC_CTRL, 8'h03);
    idle(4);
    rd_chk("guard_12m", IDX_IRQ_STAT, 8'h00);
    wr(IDX_OSC_CTRL, 8'h04);
    idle(4);
    rd_chk("guard_flag", IDX_IRQ_STAT, 8'h08);
    check("guard_irq", irq_o, 32'h1);
    wr(IDX_IRQ_STAT, 8'h08);
    wr(IDX_OSC_CTRL, 8'h00);
    wr(IDX_VDET_CTRL, 8'h26);
    wr(IDX_OSC_CTRL, 8'h07);
    idle(4);
    rd_chk("guard_high", IDX_IRQ_STAT, 8'h00);
  endtask

  task automatic t_mid_reset();
    wr(IDX_SLEEP_TRIM, 8'hc0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    idle(2);
    rst_i <= 1'b0;
    rd_chk("rst_vdet", IDX_VDET_CTRL, 8'h00);
    rd_chk("rst_trim", IDX_SLEEP_TRIM, 8'h00);
    rd_chk("rst_osc", IDX_OSC_CTRL, 8'h00);
    check("rst_high", high_trip_o, 32'h0);
  endtask

  // Firmware style speed raise, dip handling and recovery
  task automatic t_firmware();
    logic [31:0] q;
    int          n;
    n = 0;
    wr(IDX_OSC_CTRL, 8'h00);
    low_voltage_raw_i <= 1'b1;
    wr(IDX_VDET_CTRL, 8'h06);
    wr(IDX_IRQ_STAT, 8'h0f);
    wr(IDX_IRQ_MASK, 8'h08);
    do begin
      if (n == 3) low_voltage_raw_i <= 1'b0;
      bus(1'b0, IDX_VCMP_STAT, 8'h00, q);
      n++;
    end while (q[CMP_LOW_BIT] !== 1'b0);
    repeat (2) rd_chk("fw_debounce", IDX_VCMP_STAT, 8'h00);
    wr(IDX_VDET_CTRL, 8'h26);
    wr(IDX_OSC_CTRL, 8'h07);
    check("fw_speed", cpu_speed_o, 32'h7);
    rd_chk("fw_no_guard", IDX_IRQ_STAT, 8'h02);
    wr(IDX_IRQ_STAT, 8'h0f);
    wr(IDX_IRQ_MASK, 8'h01);
    low_voltage_raw_i <= 1'b1;
    idle(8);
    check("fw_dip_irq", irq_o, 32'h1);
    wr(IDX_OSC_CTRL, {5'h00, SPEED_12M_MAX});
    wr(IDX_VDET_CTRL, 8'h06);
    wr(IDX_IRQ_STAT, 8'h01);
    check("fw_isr_irq", irq_o, 32'h0);
    check("fw_isr_trip", {high_trip_o, cpu_speed_o}, {1'b0, SPEED_12M_MAX});
    low_voltage_raw_i <= 1'b0;
    do begin
      bus(1'b0, IDX_VCMP_STAT, 8'h00, q);
    end while (q[CMP_LOW_BIT] !== 1'b0);
    repeat (2) rd_chk("fw_settle", IDX_VCMP_STAT, 8'h00);
    wr(IDX_VDET_CTRL, 8'h26);
    wr(IDX_OSC_CTRL, 8'h07);
    rd_chk("fw_recover", IDX_IRQ_STAT, 8'h02);
    check("fw_back", {high_trip_o, cpu_speed_o}, 32'hf);
  endtask

  // Main sequence
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = '0;
    sel_i = 4'hf;
    dat_i = '0;
    ext_space_select_i = 1'b1;
    low_voltage_raw_i = 1'b0;
    power_reset_raw_i = 1'b0;
    idle(2);
    rst_i <= 1'b0;
    t_reset_values();
    t_masks();
    t_trip_codes();
    t_ext_flag();
    t_low_voltage();
    t_speed_guard();
    t_firmware();
    t_mid_reset();
    give_verdict();
  end

  // Watchdog
  initial begin
    idle(5000);
    fail_count++;
    give_verdict();
  end
endmodule
